// ==== include/ccm_ctrl_defs.svh ====
// Purpose: offsets, field positions and reset values of the task and
//          event control registers.
// Assumes: byte addresses on a 32-bit Avalon-MM slave.
// Notes:   every register is one aligned word.
`ifndef CCM_CTRL_DEFS_SVH
`define CCM_CTRL_DEFS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CCM_OFF_KS_START 12'h000
`define CCM_OFF_CS_START 12'h004
`define CCM_OFF_CS_HALT 12'h008
`define CCM_OFF_RATE_TRIG 12'h00C
`define CCM_OFF_KS_DONE 12'h100
`define CCM_OFF_CS_DONE 12'h104
`define CCM_OFF_FAULT 12'h108
`define CCM_OFF_LINK 12'h200
`define CCM_OFF_IEN_SET 12'h304
`define CCM_OFF_IEN_CLR 12'h308
`define CCM_OFF_IRQ_STAT 12'h30C
`define CCM_OFF_MODE 12'h504
`define CCM_OFF_RATE_SUB 12'h51C

// ****************************************************************
// field positions
// ****************************************************************
`define CCM_TRIG_BIT 0
`define CCM_FLAG_BIT 0
`define CCM_EVT_KS 0
`define CCM_EVT_CS 1
`define CCM_EVT_ERR 2
`define CCM_EVT_N 3
`define CCM_LINK_BIT 0
`define CCM_MODE_DIR_BIT 0
`define CCM_MODE_RATE_LSB 16
`define CCM_RATE_SUB_LSB 0

// ****************************************************************
// reset values
// ****************************************************************
`define CCM_RST_ZERO 32'h0000_0000
`define CCM_MODE_RESET 32'h0000_0001

`endif

// ==== include/ccm_ctrl_pkg.sv ====
// Purpose: types shared by the task and event control files.
// Assumes: nothing beyond the defs header.
// Notes:   state codes are written out.
package ccm_ctrl_pkg;

   // ****************************************************************
   // types
   // ****************************************************************
   typedef logic [1:0] bitrate_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_KS = 2'b01,
      ST_CIPHER_START_TASK = 2'b10
   } engine_state_type;

endpackage

// ==== src/sticky_flags.sv ====
// Purpose: a row of sticky flags, set by hardware, cleared by software.
// Assumes: set and clear are one-cycle pulses in the clk_i domain.
// Notes:   a set wins over a clear in the same cycle.
`timescale 1ns/1ps
module sticky_flags #(
   parameter int WIDTH = 3
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [WIDTH-1:0] set_i,
   input wire logic [WIDTH-1:0] clr_i,
   output logic [WIDTH-1:0] flag_o
);

   if (WIDTH < 1) begin : g_bad_width
      $error("sticky_flags needs WIDTH of at least one");
   end

   logic [WIDTH-1:0] flag_ff;
   logic [WIDTH-1:0] nxt_flag;

   // set first, so an event in the clearing cycle survives
   assign nxt_flag = set_i | (flag_ff & ~clr_i);
   assign flag_o = flag_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flag_ff <= '0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   property p_set_wins;
      @(posedge clk_i) disable iff (!rst_b_i)
      (set_i != '0) |=> ((flag_o & $past(set_i)) == $past(set_i));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("a flag set was lost");

endmodule

// ==== src/done_gate.sv ====
// Purpose: holds a completion until memory traffic has drained.
// Assumes: mem_busy_i is high while any memory transfer is outstanding.
// Notes:   abort_i drops a held completion.
`timescale 1ns/1ps
module done_gate (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic done_i,
   input wire logic mem_busy_i,
   input wire logic abort_i,
   output logic event_o
);

   logic pend_ff;
   logic evt_ff;
   logic want;

   assign want = done_i | pend_ff;
   assign event_o = evt_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pend_ff <= 1'b0;
         evt_ff <= 1'b0;
      end else begin
         pend_ff <= want & mem_busy_i & ~abort_i;
         evt_ff <= want & ~mem_busy_i & ~abort_i;
      end
   end

   property p_mem_drained;
      @(posedge clk_i) disable iff (!rst_b_i)
      event_o |-> !$past(mem_busy_i);
   endproperty
   a_mem_drained: assert property (p_mem_drained)
      else $error("completion raised with memory still busy");

endmodule

// ==== src/ccm_task_event_control.sv ====
// Purpose: task, event and shortcut control of a packet cipher engine.
// Assumes: Avalon-MM slave with waitrequest, byte addresses, 32-bit data;
//          the cipher datapath sits outside and talks through pulses.
// Notes:   every access takes one wait cycle.
`timescale 1ns/1ps
`include "ccm_ctrl_defs.svh"
module ccm_task_event_control #(
   parameter int ADDR_W = 12
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] address_i,
   input wire logic read_i,
   input wire logic write_i,
   input wire logic [31:0] writedata_i,
   input wire logic [3:0] byteenable_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   output logic keystream_start_task_o,
   output logic cipher_start_task_o,
   output logic cipher_halt_o,
   output logic decrypt_mode_o,
   output ccm_ctrl_pkg::bitrate_type radio_bitrate_select_o,
   output logic busy_o,
   input wire logic keystream_gen_done_i,
   input wire logic cipher_pass_done_i,
   input wire logic mem_busy_i,
   input wire logic bus_contention_i,
   output logic irq_o
);
   import ccm_ctrl_pkg::*;

   if (ADDR_W < 12) begin : g_bad_addr
      $error("ADDR_W must reach the highest register offset");
   end

   // ****************************************************************
   // bus handshake
   // ****************************************************************
   // one wait cycle lets read data come from a flip-flop
   logic ack_ff;
   logic [31:0] readdata_ff;
   wire logic req = read_i | write_i;
   wire logic wr_go = write_i & ack_ff;
   wire logic rd_load = read_i & ~ack_ff;

   assign waitrequest_o = req & ~ack_ff;
   assign readdata_o = readdata_ff;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req & ~ack_ff;
      end
   end

   // ****************************************************************
   // address decode
   // ****************************************************************
   wire logic hi_zero = ((address_i >> 12) == '0);
   wire logic [11:0] a12 = address_i[11:0];
   wire logic hit_ks = hi_zero & (a12 == `CCM_OFF_KS_START);
   wire logic hit_cs = hi_zero & (a12 == `CCM_OFF_CS_START);
   wire logic hit_halt = hi_zero & (a12 == `CCM_OFF_CS_HALT);
   wire logic hit_rtrig = hi_zero & (a12 == `CCM_OFF_RATE_TRIG);
   wire logic hit_ksd = hi_zero & (a12 == `CCM_OFF_KS_DONE);
   wire logic hit_csd = hi_zero & (a12 == `CCM_OFF_CS_DONE);
   wire logic hit_flt = hi_zero & (a12 == `CCM_OFF_FAULT);
   wire logic hit_link = hi_zero & (a12 == `CCM_OFF_LINK);
   wire logic hit_iset = hi_zero & (a12 == `CCM_OFF_IEN_SET);
   wire logic hit_iclr = hi_zero & (a12 == `CCM_OFF_IEN_CLR);
   wire logic hit_istat = hi_zero & (a12 == `CCM_OFF_IRQ_STAT);
   wire logic hit_mode = hi_zero & (a12 == `CCM_OFF_MODE);
   wire logic hit_rsub = hi_zero & (a12 == `CCM_OFF_RATE_SUB);

   wire logic wr_b0 = wr_go & byteenable_i[0];
   wire logic wr_b2 = wr_go & byteenable_i[2];
   wire logic wd_trig = writedata_i[`CCM_TRIG_BIT];
   wire logic ks_trig = wr_b0 & hit_ks & wd_trig;
   wire logic cs_trig = wr_b0 & hit_cs & wd_trig;
   wire logic halt_trig = wr_b0 & hit_halt & wd_trig;
   wire logic rate_trig = wr_b0 & hit_rtrig & wd_trig;
   wire logic [2:0] wd_evt = writedata_i[2:0];

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   localparam logic [31:0] MODE_RST = `CCM_MODE_RESET;
   localparam logic [31:0] ZERO_RST = `CCM_RST_ZERO;

   logic link_ff, mode_dir_ff;
   logic [2:0] irq_en_ff;
   bitrate_type mode_rate_ff, rate_sub_ff;

   wire logic [2:0] nxt_irq_en =
      (irq_en_ff | ({3{wr_b0 & hit_iset}} & wd_evt)) &
      ~({3{wr_b0 & hit_iclr}} & wd_evt);

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_ff <= ZERO_RST[`CCM_LINK_BIT];
         irq_en_ff <= ZERO_RST[2:0];
         mode_dir_ff <= MODE_RST[`CCM_MODE_DIR_BIT];
         mode_rate_ff <= MODE_RST[`CCM_MODE_RATE_LSB +: 2];
         rate_sub_ff <= ZERO_RST[`CCM_RATE_SUB_LSB +: 2];
      end else begin
         irq_en_ff <= nxt_irq_en;
         if (wr_b0 & hit_link) begin
            link_ff <= writedata_i[`CCM_LINK_BIT];
         end
         if (wr_b0 & hit_mode) begin
            mode_dir_ff <= writedata_i[`CCM_MODE_DIR_BIT];
         end
         if (wr_b2 & hit_mode) begin
            mode_rate_ff <= writedata_i[`CCM_MODE_RATE_LSB +: 2];
         end
         if (wr_b0 & hit_rsub) begin
            rate_sub_ff <= writedata_i[`CCM_RATE_SUB_LSB +: 2];
         end
      end
   end

   // ****************************************************************
   // engine sequencing
   // ****************************************************************
   engine_state_type state_ff, nxt_state;
   logic start_ks, start_cs, ks_evt, cs_evt;
   logic ks_start_ff, cs_start_ff, halt_ff, decrypt_ff;
   bitrate_type bitrate_ff;

   wire logic in_ks = (state_ff == ST_KS);
   wire logic in_cs = (state_ff == ST_CIPHER_START_TASK);
   wire logic halt_go = halt_trig & in_cs;
   wire logic err_evt = bus_contention_i & (state_ff != ST_IDLE);

   done_gate u_ks_gate (
      .clk_i(clk_i), .rst_b_i(rst_b_i),
      .done_i(keystream_gen_done_i & in_ks), .mem_busy_i(mem_busy_i),
      .abort_i(1'b0), .event_o(ks_evt)
   );

   done_gate u_cs_gate (
      .clk_i(clk_i), .rst_b_i(rst_b_i),
      .done_i(cipher_pass_done_i & in_cs), .mem_busy_i(mem_busy_i),
      .abort_i(halt_go), .event_o(cs_evt)
   );

   // start triggers are taken only while idle; the datapath has one pass at a time
   always_comb begin
      nxt_state = state_ff;
      start_ks = 1'b0;
      start_cs = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (ks_trig) begin
               nxt_state = ST_KS;
               start_ks = 1'b1;
            end else if (cs_trig) begin
               nxt_state = ST_CIPHER_START_TASK;
               start_cs = 1'b1;
            end
         end
         ST_KS: begin
            if (ks_evt && link_ff) begin
               nxt_state = ST_CIPHER_START_TASK;
               start_cs = 1'b1;
            end else if (ks_evt) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_CIPHER_START_TASK: begin
            if (halt_go) begin
               nxt_state = ST_IDLE;
            end else if (cs_evt) begin
               nxt_state = ST_IDLE;
            end
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   wire logic any_start = start_ks | start_cs;
   wire logic rate_go = rate_trig & in_cs;

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_IDLE;
         ks_start_ff <= 1'b0;
         cs_start_ff <= 1'b0;
         halt_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         ks_start_ff <= start_ks;
         cs_start_ff <= start_cs;
         halt_ff <= halt_go;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         decrypt_ff <= MODE_RST[`CCM_MODE_DIR_BIT];
         bitrate_ff <= MODE_RST[`CCM_MODE_RATE_LSB +: 2];
      end else if (any_start) begin
         decrypt_ff <= mode_dir_ff;
         bitrate_ff <= mode_rate_ff;
      end else if (rate_go) begin
         bitrate_ff <= rate_sub_ff;
      end
   end

   assign keystream_start_task_o = ks_start_ff;
   assign cipher_start_task_o = cs_start_ff;
   assign cipher_halt_o = halt_ff;
   assign decrypt_mode_o = decrypt_ff;
   assign radio_bitrate_select_o = bitrate_ff;
   assign busy_o = (state_ff != ST_IDLE);

   // ****************************************************************
   // event flags and interrupt
   // ****************************************************************
   logic [2:0] evt_q, istat_q;
   wire logic [2:0] evt_set = {err_evt, cs_evt, ks_evt};
   // writing zero clears an event register; a one is ignored
   wire logic clr_flag = wr_b0 & ~writedata_i[`CCM_FLAG_BIT];
   wire logic [2:0] evt_clr = {clr_flag & hit_flt, clr_flag & hit_csd,
      clr_flag & hit_ksd};
   wire logic [2:0] istat_clr = {3{wr_b0 & hit_istat}} & wd_evt;

   sticky_flags #(
      .WIDTH(`CCM_EVT_N)
   ) u_evt_flags (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .set_i(evt_set),
      .clr_i(evt_clr),
      .flag_o(evt_q)
   );

   sticky_flags #(
      .WIDTH(`CCM_EVT_N)
   ) u_irq_stat (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .set_i(evt_set),
      .clr_i(istat_clr),
      .flag_o(istat_q)
   );

   assign irq_o = |(istat_q & irq_en_ff);

   // ****************************************************************
   // read mux
   // ****************************************************************
   // trigger registers are write-only and read as zero
   wire logic [31:0] rd_word =
      ({32{hit_ksd}} & {31'h0000_0000, evt_q[`CCM_EVT_KS]}) |
      ({32{hit_csd}} & {31'h0000_0000, evt_q[`CCM_EVT_CS]}) |
      ({32{hit_flt}} & {31'h0000_0000, evt_q[`CCM_EVT_ERR]}) |
      ({32{hit_link}} & {31'h0000_0000, link_ff}) |
      ({32{hit_iset | hit_iclr}} & {29'h0000_0000, irq_en_ff}) |
      ({32{hit_istat}} & {29'h0000_0000, istat_q}) |
      ({32{hit_mode}} & {14'h0000, mode_rate_ff, 15'h0000, mode_dir_ff}) |
      ({32{hit_rsub}} & {30'h0000_0000, rate_sub_ff});

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         readdata_ff <= ZERO_RST;
      end else if (rd_load) begin
         readdata_ff <= rd_word;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   property p_ks_start;
      @(posedge clk_i) disable iff (!rst_b_i)
      (ks_trig && state_ff == ST_IDLE) |=>
         (keystream_start_task_o && state_ff == ST_KS);
   endproperty
   a_ks_start: assert property (p_ks_start)
      else $error("key-stream trigger did not start generation");

   property p_cs_start;
      @(posedge clk_i) disable iff (!rst_b_i)
      (cs_trig && !ks_trig && state_ff == ST_IDLE) |=>
         (cipher_start_task_o && busy_o) ##1 !cipher_start_task_o;
   endproperty
   a_cs_start: assert property (p_cs_start)
      else $error("cipher trigger did not give a single start pulse");

   property p_rate_sub;
      @(posedge clk_i) disable iff (!rst_b_i)
      rate_go |=> (radio_bitrate_select_o == $past(rate_sub_ff));
   endproperty
   a_rate_sub: assert property (p_rate_sub)
      else $error("rate substitute not applied to running pass");

   property p_chain_on;
      @(posedge clk_i) disable iff (!rst_b_i)
      (ks_evt && in_ks && link_ff) |=>
         (cipher_start_task_o && state_ff == ST_CIPHER_START_TASK);
   endproperty
   a_chain_on: assert property (p_chain_on)
      else $error("linked key-stream completion did not start cipher");

   property p_chain_off;
      @(posedge clk_i) disable iff (!rst_b_i)
      (ks_evt && in_ks && !link_ff) |=>
         (!cipher_start_task_o && state_ff == ST_IDLE);
   endproperty
   a_chain_off: assert property (p_chain_off)
      else $error("unlinked key-stream completion started cipher");

   property p_halt;
      @(posedge clk_i) disable iff (!rst_b_i)
      halt_go |=> (cipher_halt_o && !busy_o) ##1 !cipher_halt_o;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt trigger did not abort the cipher pass");

   property p_done_flag;
      @(posedge clk_i) disable iff (!rst_b_i)
      $rose(evt_q[`CCM_EVT_CS]) |-> $past(cs_evt) && !$past(mem_busy_i, 2);
   endproperty
   a_done_flag: assert property (p_done_flag)
      else $error("cipher done flag set without drained memory");

   property p_fault;
      @(posedge clk_i) disable iff (!rst_b_i)
      (bus_contention_i && busy_o) |=> evt_q[`CCM_EVT_ERR];
   endproperty
   a_fault: assert property (p_fault)
      else $error("contention while busy did not raise error flag");

   property p_mode_sample;
      @(posedge clk_i) disable iff (!rst_b_i)
      any_start |=> (decrypt_mode_o == $past(mode_dir_ff)) &&
         (radio_bitrate_select_o == $past(mode_rate_ff));
   endproperty
   a_mode_sample: assert property (p_mode_sample)
      else $error("mode not sampled at start");

   property p_ien_set;
      @(posedge clk_i) disable iff (!rst_b_i)
      (wr_b0 && hit_iset) |=>
         ((irq_en_ff & $past(wd_evt)) == $past(wd_evt)) &&
         ((irq_en_ff | $past(wd_evt)) == ($past(irq_en_ff) | $past(wd_evt)));
   endproperty
   a_ien_set: assert property (p_ien_set)
      else $error("interrupt enable set write misbehaved");

endmodule

// ==== bench/ccm_task_event_control_test.sv ====
// Purpose: self-checking bench for the task, event and shortcut control.
// Assumes: one wait cycle per access, pulses and mode outputs registered.
// Notes:   the bench stands in for the cipher datapath at the lower ports.
`timescale 1ns/1ps
module ccm_task_event_control_test;
   import ccm_ctrl_pkg::*;

   // ****************************************************************
   // signals and design
   // ****************************************************************
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [11:0] address_i = 12'h000;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0000_0000;
   logic [3:0] byteenable_i = 4'hf;
   logic keystream_gen_done_i = 1'b0;
   logic cipher_pass_done_i = 1'b0;
   logic mem_busy_i = 1'b0;
   logic bus_contention_i = 1'b0;
   logic [31:0] readdata_o;
   logic waitrequest_o, keystream_start_task_o, cipher_start_task_o;
   logic cipher_halt_o, decrypt_mode_o, busy_o, irq_o;
   bitrate_type radio_bitrate_select_o;
   int fails = 0;
   int checked = 0;
   int ks_cnt = 0;
   int cs_cnt = 0;
   int halt_cnt = 0;

   ccm_task_event_control i_dut (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .address_i(address_i),
      .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
      .byteenable_i(byteenable_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o),
      .keystream_start_task_o(keystream_start_task_o),
      .cipher_start_task_o(cipher_start_task_o),
      .cipher_halt_o(cipher_halt_o), .decrypt_mode_o(decrypt_mode_o),
      .radio_bitrate_select_o(radio_bitrate_select_o), .busy_o(busy_o),
      .keystream_gen_done_i(keystream_gen_done_i),
      .cipher_pass_done_i(cipher_pass_done_i), .mem_busy_i(mem_busy_i),
      .bus_contention_i(bus_contention_i), .irq_o(irq_o)
   );

   always #50 clk_i = ~clk_i;

   // pulses are counted per high cycle, so a stretched pulse shows up
   always @(posedge clk_i) begin
      if (keystream_start_task_o === 1'b1) ks_cnt++;
      if (cipher_start_task_o === 1'b1) cs_cnt++;
      if (cipher_halt_o === 1'b1) halt_cnt++;
   end

   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic results;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string m);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got,
                  exp);
      end
   endtask

   // waitrequest and readdata are taken at the rising edge itself, before
   // that edge's register updates land, so the answer is the settled one
   task automatic acc(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= d;
      if (wr) begin
         write_i <= 1'b1;
      end else begin
         read_i <= 1'b1;
      end
      do begin
         @(posedge clk_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      q = readdata_o;
      if (waitrequest_o !== 1'b0) begin
         fails++;
         $display("CHECK FAILED at %0t: no bus answer", $time);
      end
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      acc(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      acc(1'b0, a, 32'h0000_0000, q);
      chk(q, exp, "readback");
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask

   task automatic pulse(input int which);
      @(posedge clk_i);
      case (which)
         0: keystream_gen_done_i <= 1'b1;
         1: cipher_pass_done_i <= 1'b1;
         default: bus_contention_i <= 1'b1;
      endcase
      @(posedge clk_i);
      keystream_gen_done_i <= 1'b0;
      cipher_pass_done_i <= 1'b0;
      bus_contention_i <= 1'b0;
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      logic [11:0] offs [13];
      offs = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h100, 12'h104,
               12'h108, 12'h200, 12'h304, 12'h30c, 12'h504, 12'h51c,
               12'h7f0};
      repeat (3) @(posedge clk_i);
      rst_b_i <= 1'b1;
      foreach (offs[i]) rd_chk(offs[i], (offs[i] == 12'h504));
      chk(busy_o, 32'h0000_0000, "busy after reset");
      chk(decrypt_mode_o, 32'h0000_0001, "mode after reset");
      wr(12'h7f0, 32'hffff_ffff);
      rd_chk(12'h7f0, 32'h0000_0000);
      // mode written while idle only lands at the next start
      wr(12'h504, 32'h0002_0000);
      idle(1);
      chk(decrypt_mode_o, 32'h0000_0001, "mode before start");
      wr(12'h000, 32'h0000_0001);
      idle(2);
      chk(ks_cnt, 32'h0000_0001, "ks start pulse");
      chk(busy_o, 32'h0000_0001, "busy in ks");
      chk(decrypt_mode_o, 32'h0000_0000, "mode at start");
      chk(radio_bitrate_select_o, 32'h0000_0002, "rate at start");
      wr(12'h504, 32'h0000_0001);
      idle(1);
      chk(decrypt_mode_o, 32'h0000_0000, "mode held while busy");
      // completion waits for memory traffic to drain
      @(posedge clk_i);
      mem_busy_i <= 1'b1;
      pulse(0);
      idle(4);
      rd_chk(12'h100, 32'h0000_0000);
      mem_busy_i <= 1'b0;
      idle(3);
      rd_chk(12'h100, 32'h0000_0001);
      chk(busy_o, 32'h0000_0000, "ks ends by itself");
      chk(cs_cnt, 32'h0000_0000, "no chain when link off");
      // linked run, then a rate substitute mid-pass
      wr(12'h200, 32'h0000_0001);
      rd_chk(12'h200, 32'h0000_0001);
      wr(12'h000, 32'h0000_0001);
      pulse(0);
      idle(3);
      chk(cs_cnt, 32'h0000_0001, "chained cipher start");
      chk(busy_o, 32'h0000_0001, "busy in cipher");
      chk(decrypt_mode_o, 32'h0000_0001, "mode at second start");
      wr(12'h51c, 32'h0000_0003);
      idle(1);
      chk(radio_bitrate_select_o, 32'h0000_0000, "rate not yet");
      wr(12'h00c, 32'h0000_0001);
      idle(2);
      chk(radio_bitrate_select_o, 32'h0000_0003, "rate substituted");
      pulse(1);
      idle(3);
      rd_chk(12'h104, 32'h0000_0001);
      chk(busy_o, 32'h0000_0000, "cipher ends by itself");
      wr(12'h104, 32'h0000_0000);
      rd_chk(12'h104, 32'h0000_0000);
      wr(12'h104, 32'h0000_0001);
      rd_chk(12'h104, 32'h0000_0000);
      // direct cipher start, contention, then an abort
      wr(12'h200, 32'h0000_0000);
      wr(12'h004, 32'h0000_0001);
      idle(2);
      chk(cs_cnt, 32'h0000_0002, "direct cipher start");
      chk(busy_o, 32'h0000_0001, "busy in direct cipher");
      pulse(2);
      idle(2);
      rd_chk(12'h108, 32'h0000_0001);
      mem_busy_i <= 1'b1;
      pulse(1);
      wr(12'h008, 32'h0000_0001);
      idle(2);
      chk(halt_cnt, 32'h0000_0001, "halt pulse");
      chk(busy_o, 32'h0000_0000, "halted");
      @(posedge clk_i);
      mem_busy_i <= 1'b0;
      idle(3);
      rd_chk(12'h104, 32'h0000_0000);
      // interrupt status, enable set and clear
      rd_chk(12'h30c, 32'h0000_0007);
      chk(irq_o, 32'h0000_0000, "irq masked");
      wr(12'h304, 32'h0000_0002);
      idle(1);
      chk(irq_o, 32'h0000_0001, "irq enabled");
      wr(12'h304, 32'h0000_0000);
      rd_chk(12'h304, 32'h0000_0002);
      wr(12'h30c, 32'h0000_0002);
      idle(1);
      chk(irq_o, 32'h0000_0000, "irq cleared");
      rd_chk(12'h30c, 32'h0000_0005);
      wr(12'h308, 32'h0000_0002);
      rd_chk(12'h308, 32'h0000_0000);
      wr(12'h304, 32'h0000_0001);
      idle(1);
      chk(irq_o, 32'h0000_0001, "irq from ks status");
      // reset while idle returns the flags, enables and irq to zero
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      idle(2);
      chk(irq_o, 32'h0000_0000, "irq in reset");
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      rd_chk(12'h100, 32'h0000_0000);
      rd_chk(12'h304, 32'h0000_0000);
      results();
   end

   // the tests need well under a thousand cycles
   initial begin
      #2_000_000;
      fails++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      results();
   end
endmodule
